// ==== hw/isc_pkg.sv ====
// Constants and types for the instruction state counter
package isc_pkg;
  typedef enum logic [2:0] {
    ISC_FETCH = 3'b000,
    ISC_BRANCH = 3'b001,
    ISC_STACK = 3'b010,
    ISC_BYTE = 3'b011,
    ISC_WORD = 3'b100,
    ISC_INTERNAL = 3'b101
  } isc_kind_t;

  typedef enum logic [0:0] {
    ISC_IDLE = 1'b0,
    ISC_BUSY = 1'b1
  } isc_phase_t;

  // State cost of each cycle kind
  localparam logic [3:0] COST_MEM = 4'h2;
  localparam logic [3:0] COST_PERIPH_FAST = 4'h2;
  localparam logic [3:0] COST_PERIPH_SLOW = 4'h3;
  localparam logic [3:0] COST_INTERNAL = 4'h1;

  // Opcode fields
  localparam logic [7:0] OP_IMM32_GROUP = 8'h7A;
  localparam logic [3:0] OP_IMM32_ADD = 4'h1;
  localparam logic [3:0] OP_IMM32_AND = 4'h6;
  localparam logic [7:0] OP_BIT_IND_A = 8'h7C;
  localparam logic [7:0] OP_BIT_IND_B = 8'h7D;
  localparam logic [7:0] OP_BIT_ABS_A = 8'h7E;
  localparam logic [7:0] OP_BIT_ABS_B = 8'h7F;
  localparam int REG_SEL_LSB = 4;
  localparam logic [7:0] IMM32_FETCHES = 8'h03;

  localparam logic [15:0] RESET_ACC = 16'h0000;
  localparam logic [7:0] RESET_COUNT = 8'h00;
endpackage

// ==== hw/isc_counter.sv ====
// Instruction execution state counter
`timescale 1ns/1ps
module isc_counter (
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic instr_start,
  input wire logic [7:0] opcode_hi,
  input wire logic [7:0] opcode_lo,
  input wire logic cycle_valid,
  input wire isc_pkg::isc_kind_t cycle_kind,
  input wire logic cycle_periph,
  input wire logic periph_slow,
  input wire logic cycle_last,
  output logic [15:0] state_total,
  output logic total_valid,
  output logic [7:0] fetch_count,
  output logic [7:0] branch_count,
  output logic [7:0] stack_count,
  output logic [7:0] byte_count,
  output logic [7:0] word_count,
  output logic [7:0] internal_count,
  output logic imm32_add,
  output logic imm32_and,
  output logic profile_error,
  output logic bit_reg_indirect,
  output logic bit_absolute,
  output logic [2:0] bit_reg_sel,
  output logic [7:0] bit_abs_addr
);
  typedef struct packed {
    isc_pkg::isc_phase_t phase;
    logic [15:0] acc;
    logic [15:0] total;
    logic done;
    logic [7:0] n_fetch;
    logic [7:0] n_branch;
    logic [7:0] n_stack;
    logic [7:0] n_byte;
    logic [7:0] n_word;
    logic [7:0] n_internal;
    logic periph_seen;
    logic imm_add;
    logic imm_and;
    logic err;
    logic bit_ind;
    logic bit_abs;
    logic [2:0] reg_sel;
    logic [7:0] abs_addr;
  } isc_state_t;

  isc_state_t st;
  isc_state_t next_st;
  logic [3:0] cyc_cost;
  logic cyc_take;

  // Peripheral figures apply to data access only; code and stack are in
  // on-chip memory, so any location flag on those kinds is ignored.
  function automatic logic [3:0] cost_of(isc_pkg::isc_kind_t kind,
                                         logic periph, logic slow);
    logic [3:0] c;
    c = isc_pkg::COST_MEM;
    case (kind)
      isc_pkg::ISC_BYTE, isc_pkg::ISC_WORD: begin
        if (periph) begin
          c = slow ? isc_pkg::COST_PERIPH_SLOW
                   : isc_pkg::COST_PERIPH_FAST;
        end else begin
          c = isc_pkg::COST_MEM;
        end
      end
      isc_pkg::ISC_INTERNAL: c = isc_pkg::COST_INTERNAL;
      default: c = isc_pkg::COST_MEM;
    endcase
    return c;
  endfunction

  function automatic logic [15:0] mem_weight(isc_state_t s);
    return {7'h00, s.n_fetch, 1'b0} + {7'h00, s.n_branch, 1'b0}
         + {7'h00, s.n_stack, 1'b0} + {7'h00, s.n_byte, 1'b0}
         + {7'h00, s.n_word, 1'b0} + {8'h00, s.n_internal};
  endfunction

  assign cyc_take = cycle_valid
    && (instr_start || st.phase == isc_pkg::ISC_BUSY);
  assign cyc_cost = cost_of(cycle_kind, cycle_periph, periph_slow);

  always_comb begin
    logic is_imm;
    logic end_now;
    is_imm = 1'b0;
    end_now = 1'b0;
    next_st = st;
    next_st.done = 1'b0;
    if (instr_start) begin
      next_st.phase = isc_pkg::ISC_BUSY;
      next_st.acc = isc_pkg::RESET_ACC;
      next_st.n_fetch = isc_pkg::RESET_COUNT;
      next_st.n_branch = isc_pkg::RESET_COUNT;
      next_st.n_stack = isc_pkg::RESET_COUNT;
      next_st.n_byte = isc_pkg::RESET_COUNT;
      next_st.n_word = isc_pkg::RESET_COUNT;
      next_st.n_internal = isc_pkg::RESET_COUNT;
      next_st.periph_seen = 1'b0;
      next_st.err = 1'b0;
      next_st.imm_add = opcode_hi == isc_pkg::OP_IMM32_GROUP
        && opcode_lo[7:4] == isc_pkg::OP_IMM32_ADD && !opcode_lo[3];
      next_st.imm_and = opcode_hi == isc_pkg::OP_IMM32_GROUP
        && opcode_lo[7:4] == isc_pkg::OP_IMM32_AND && !opcode_lo[3];
      next_st.bit_ind = opcode_hi == isc_pkg::OP_BIT_IND_A
        || opcode_hi == isc_pkg::OP_BIT_IND_B;
      next_st.bit_abs = opcode_hi == isc_pkg::OP_BIT_ABS_A
        || opcode_hi == isc_pkg::OP_BIT_ABS_B;
      next_st.reg_sel = next_st.bit_ind
        ? opcode_lo[isc_pkg::REG_SEL_LSB +: 3] : 3'h0;
      next_st.abs_addr = next_st.bit_abs ? opcode_lo : 8'h00;
    end
    is_imm = next_st.imm_add || next_st.imm_and;
    if (cyc_take) begin
      next_st.acc = next_st.acc + {12'h000, cyc_cost};
      if (cycle_periph && (cycle_kind == isc_pkg::ISC_BYTE
          || cycle_kind == isc_pkg::ISC_WORD)) begin
        next_st.periph_seen = 1'b1;
      end
      case (cycle_kind)
        isc_pkg::ISC_FETCH: next_st.n_fetch = next_st.n_fetch + 8'h01;
        isc_pkg::ISC_BRANCH: next_st.n_branch = next_st.n_branch + 8'h01;
        isc_pkg::ISC_STACK: next_st.n_stack = next_st.n_stack + 8'h01;
        isc_pkg::ISC_BYTE: next_st.n_byte = next_st.n_byte + 8'h01;
        isc_pkg::ISC_WORD: next_st.n_word = next_st.n_word + 8'h01;
        default: next_st.n_internal = next_st.n_internal + 8'h01;
      endcase
      // Immediate 32-bit ops end on their third fetch whatever the
      // sequencer says; any other kind is flagged as a profile fault.
      if (is_imm) begin
        if (cycle_kind != isc_pkg::ISC_FETCH) begin
          next_st.err = 1'b1;
        end
        end_now = next_st.n_fetch == isc_pkg::IMM32_FETCHES;
      end else begin
        end_now = cycle_last;
      end
      if (end_now) begin
        next_st.total = next_st.acc;
        next_st.done = 1'b1;
        next_st.phase = isc_pkg::ISC_IDLE;
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign state_total = st.total;
  assign total_valid = st.done;
  assign fetch_count = st.n_fetch;
  assign branch_count = st.n_branch;
  assign stack_count = st.n_stack;
  assign byte_count = st.n_byte;
  assign word_count = st.n_word;
  assign internal_count = st.n_internal;
  assign imm32_add = st.imm_add;
  assign imm32_and = st.imm_and;
  assign profile_error = st.err;
  assign bit_reg_indirect = st.bit_ind;
  assign bit_absolute = st.bit_abs;
  assign bit_reg_sel = st.reg_sel;
  assign bit_abs_addr = st.abs_addr;

  a_total_weighted: assert property (
    @(posedge clk_sys) disable iff (reset)
    total_valid && !st.periph_seen |-> state_total == mem_weight(st))
    else $error("total differs from weighted cycle counts");

  a_fetch_two: assert property (
    @(posedge clk_sys) disable iff (reset)
    cyc_take && !instr_start && cycle_kind == isc_pkg::ISC_FETCH
    |=> st.acc == $past(st.acc) + 16'h0002)
    else $error("fetch cycle not charged two states");

  a_byte_ram_two: assert property (
    @(posedge clk_sys) disable iff (reset)
    cyc_take && !instr_start && cycle_kind == isc_pkg::ISC_BYTE
    && !cycle_periph |=> st.acc == $past(st.acc) + 16'h0002)
    else $error("on-chip byte access not charged two states");

  a_stack_two: assert property (
    @(posedge clk_sys) disable iff (reset)
    cyc_take && !instr_start && (cycle_kind == isc_pkg::ISC_STACK
    || cycle_kind == isc_pkg::ISC_BRANCH)
    |=> st.acc == $past(st.acc) + 16'h0002)
    else $error("branch or stack cycle not charged two states");

  a_periph_cost: assert property (
    @(posedge clk_sys) disable iff (reset)
    cyc_take && !instr_start && cycle_kind == isc_pkg::ISC_BYTE
    && cycle_periph |=> st.acc == $past(st.acc)
    + ($past(periph_slow) ? 16'h0003 : 16'h0002))
    else $error("peripheral byte access cost wrong");

  a_imm_add_end: assert property (
    @(posedge clk_sys) disable iff (reset)
    cyc_take && !instr_start && st.imm_add && st.n_fetch == 8'h02
    && cycle_kind == isc_pkg::ISC_FETCH
    |=> total_valid && fetch_count == 8'h03)
    else $error("imm add did not end on third fetch");

  a_imm_add_total: assert property (
    @(posedge clk_sys) disable iff (reset)
    total_valid && imm32_add && !profile_error
    |-> fetch_count == 8'h03 && state_total == 16'h0006)
    else $error("imm add not three fetches");

  a_imm_and_total: assert property (
    @(posedge clk_sys) disable iff (reset)
    total_valid && imm32_and |-> fetch_count == 8'h03
    && (profile_error || (branch_count == 8'h00 && byte_count == 8'h00
    && stack_count == 8'h00 && word_count == 8'h00
    && internal_count == 8'h00)))
    else $error("imm AND profile wrong");

  a_bit_reg_field: assert property (
    @(posedge clk_sys) disable iff (reset)
    instr_start && (opcode_hi == 8'h7C || opcode_hi == 8'h7D)
    |=> bit_reg_indirect && !bit_absolute
    && bit_reg_sel == $past(opcode_lo[6:4]))
    else $error("register field not taken");

  a_bit_abs_field: assert property (
    @(posedge clk_sys) disable iff (reset)
    instr_start && (opcode_hi == 8'h7E || opcode_hi == 8'h7F)
    |=> bit_absolute && bit_abs_addr == $past(opcode_lo))
    else $error("absolute field not taken");

  a_start_clears: assert property (
    @(posedge clk_sys) disable iff (reset)
    instr_start && cycle_valid && cycle_kind == isc_pkg::ISC_FETCH
    && !cycle_last |=> st.acc == 16'h0002 && fetch_count == 8'h01
    && branch_count == 8'h00 && stack_count == 8'h00
    && byte_count == 8'h00 && !total_valid)
    else $error("start did not clear count");

  a_end_presents: assert property (
    @(posedge clk_sys) disable iff (reset)
    cyc_take && !instr_start && cycle_last && !st.imm_add && !st.imm_and
    |=> total_valid
    && state_total == $past(st.acc) + {12'h000, $past(cyc_cost)})
    else $error("total not presented at last cycle");
endmodule // isc_counter

// ==== bench/isc_seq_model.sv ====
// Behavioural model of the instruction sequencer feeding the counter
`timescale 1ns/1ps
module isc_seq_model (
  input wire logic clk_sys,
  output logic instr_start,
  output logic [7:0] opcode_hi,
  output logic [7:0] opcode_lo,
  output logic cycle_valid,
  output isc_pkg::isc_kind_t cycle_kind,
  output logic cycle_periph,
  output logic periph_slow,
  output logic cycle_last
);
  initial begin
    instr_start = 1'b0;
    {opcode_hi, opcode_lo} = 16'h0000;
    cycle_valid = 1'b0;
    cycle_kind = isc_pkg::ISC_FETCH;
    {cycle_periph, periph_slow, cycle_last} = 3'h0;
  end
  // One cycle per call, driven at the falling edge so calls run back to back
  task automatic cyc(input logic st, input logic [15:0] op,
    input isc_pkg::isc_kind_t k, input logic per, input logic slow,
    input logic last);
    @(negedge clk_sys);
    instr_start = st;
    {opcode_hi, opcode_lo} = st ? op : ~{opcode_hi, opcode_lo};
    cycle_valid = 1'b1;
    cycle_kind = k;
    {cycle_periph, periph_slow, cycle_last} = {per, slow, last};
  endtask
  // Released qualifiers flip so a stale value never passes for a live one
  task automatic idle();
    @(negedge clk_sys);
    instr_start = 1'b0;
    cycle_valid = 1'b0;
    {opcode_hi, opcode_lo} = ~{opcode_hi, opcode_lo};
    {cycle_periph, periph_slow, cycle_last} =
      ~{cycle_periph, periph_slow, cycle_last};
  endtask
endmodule // isc_seq_model

// ==== bench/test_instruction_state_counter.sv ====
// Self-checking testbench of the instruction state counter
`timescale 1ns/1ps
module test_instruction_state_counter;
  localparam isc_pkg::isc_kind_t KF = isc_pkg::ISC_FETCH;
  localparam isc_pkg::isc_kind_t KB = isc_pkg::ISC_BRANCH;
  localparam isc_pkg::isc_kind_t KS = isc_pkg::ISC_STACK;
  localparam isc_pkg::isc_kind_t KY = isc_pkg::ISC_BYTE;
  localparam isc_pkg::isc_kind_t KW = isc_pkg::ISC_WORD;
  localparam isc_pkg::isc_kind_t KN = isc_pkg::ISC_INTERNAL;
  logic clk_sys, reset, instr_start, cycle_valid, cycle_periph;
  logic periph_slow, cycle_last, total_valid, imm32_add, imm32_and;
  logic profile_error, bit_reg_indirect, bit_absolute;
  logic [7:0] opcode_hi, opcode_lo, fetch_count, branch_count;
  logic [7:0] stack_count, byte_count, word_count, internal_count;
  logic [7:0] bit_abs_addr;
  logic [2:0] bit_reg_sel;
  logic [15:0] state_total;
  isc_pkg::isc_kind_t cycle_kind;
  int n_fail = 0;
  int check_count = 0;
  isc_seq_model m (.clk_sys(clk_sys), .instr_start(instr_start),
    .opcode_hi(opcode_hi), .opcode_lo(opcode_lo), .cycle_valid(cycle_valid),
    .cycle_kind(cycle_kind), .cycle_periph(cycle_periph),
    .periph_slow(periph_slow), .cycle_last(cycle_last));
  isc_counter uut (.clk_sys(clk_sys), .reset(reset),
    .instr_start(instr_start), .opcode_hi(opcode_hi),
    .opcode_lo(opcode_lo), .cycle_valid(cycle_valid),
    .cycle_kind(cycle_kind), .cycle_periph(cycle_periph),
    .periph_slow(periph_slow), .cycle_last(cycle_last),
    .state_total(state_total), .total_valid(total_valid),
    .fetch_count(fetch_count), .branch_count(branch_count),
    .stack_count(stack_count), .byte_count(byte_count),
    .word_count(word_count), .internal_count(internal_count),
    .imm32_add(imm32_add), .imm32_and(imm32_and),
    .profile_error(profile_error), .bit_reg_indirect(bit_reg_indirect),
    .bit_absolute(bit_absolute), .bit_reg_sel(bit_reg_sel),
    .bit_abs_addr(bit_abs_addr));
  initial begin
    clk_sys = 1'b0;
    forever #2 clk_sys = ~clk_sys;
  end
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    check_count++;
    if (seen !== exp) begin
      n_fail++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  // The total is looked at in the one cycle that total_valid stands
  task automatic ended(input logic [15:0] tot);
    m.idle();
    check(total_valid, 1'b1);
    check(state_total, tot);
  endtask
  // First fetch also raises cycle_last, which these instructions ignore
  task automatic t_imm32(input logic [7:0] lo, input logic add);
    m.cyc(1'b1, {8'h7A, lo}, KF, 1'b0, 1'b0, 1'b1);
    m.cyc(1'b0, 16'h0000, KF, 1'b0, 1'b0, 1'b0);
    m.cyc(1'b0, 16'h0000, KF, 1'b0, 1'b0, 1'b0);
    ended(16'h0006);
    check(fetch_count, 8'h03);
    check({imm32_add, imm32_and}, {add, ~add});
    check(profile_error, 1'b0);
  endtask
  // A non-fetch cycle inside a 32-bit immediate op is flagged, not ended
  task automatic t_imm_fault();
    m.cyc(1'b1, 16'h7A10, KF, 1'b0, 1'b0, 1'b0);
    m.cyc(1'b0, 16'h0000, KN, 1'b0, 1'b0, 1'b1);
    m.cyc(1'b0, 16'h0000, KF, 1'b0, 1'b0, 1'b0);
    m.cyc(1'b0, 16'h0000, KF, 1'b0, 1'b0, 1'b0);
    ended(16'h0007);
    check({profile_error, internal_count}, 9'h101);
  endtask
  task automatic t_bit_ram();
    m.cyc(1'b1, 16'h7D30, KF, 1'b0, 1'b0, 1'b0);
    m.cyc(1'b0, 16'h0000, KF, 1'b0, 1'b0, 1'b0);
    m.cyc(1'b0, 16'h0000, KY, 1'b0, 1'b0, 1'b0);
    m.cyc(1'b0, 16'h0000, KY, 1'b0, 1'b0, 1'b1);
    ended(16'h0008);
    check(byte_count, 8'h02);
    check({bit_reg_indirect, bit_absolute}, 2'b10);
    check(bit_reg_sel, 3'h3);
    m.idle();
    check(total_valid, 1'b0);
  endtask
  task automatic t_call();
    m.cyc(1'b1, 16'h5D00, KF, 1'b0, 1'b0, 1'b0);
    m.cyc(1'b0, 16'h0000, KF, 1'b0, 1'b0, 1'b0);
    m.cyc(1'b0, 16'h0000, KB, 1'b0, 1'b0, 1'b0);
    m.cyc(1'b0, 16'h0000, KS, 1'b0, 1'b0, 1'b1);
    ended(16'h0008);
    check({branch_count, stack_count}, 16'h0101);
  endtask
  task automatic t_periph();
    m.cyc(1'b1, 16'h7FA4, KF, 1'b0, 1'b0, 1'b0);
    m.cyc(1'b0, 16'h0000, KY, 1'b1, 1'b1, 1'b0);
    m.cyc(1'b0, 16'h0000, KY, 1'b1, 1'b0, 1'b0);
    m.cyc(1'b0, 16'h0000, KW, 1'b1, 1'b1, 1'b1);
    ended(16'h000A);
    check({bit_reg_indirect, bit_absolute}, 2'b01);
    check(bit_abs_addr, 8'hA4);
  endtask
  task automatic t_mix();
    m.cyc(1'b1, 16'h0100, KF, 1'b0, 1'b0, 1'b0);
    m.cyc(1'b0, 16'h0000, KN, 1'b0, 1'b0, 1'b0);
    m.cyc(1'b0, 16'h0000, KW, 1'b0, 1'b0, 1'b0);
    m.cyc(1'b0, 16'h0000, KS, 1'b0, 1'b0, 1'b1);
    ended(16'h0007);
    check({internal_count, word_count}, 16'h0101);
  endtask
  // Restart mid-instruction, then a stray cycle with none open
  task automatic t_restart();
    m.cyc(1'b1, 16'h7C50, KF, 1'b0, 1'b0, 1'b0);
    m.cyc(1'b0, 16'h0000, KF, 1'b0, 1'b0, 1'b0);
    m.cyc(1'b1, 16'h7E11, KF, 1'b0, 1'b0, 1'b1);
    ended(16'h0002);
    check({bit_reg_indirect, bit_absolute, bit_abs_addr}, 10'h111);
    m.cyc(1'b0, 16'h0000, KF, 1'b0, 1'b0, 1'b1);
    m.idle();
    check({total_valid, fetch_count}, 9'h001);
  endtask
  task automatic t_reset();
    m.cyc(1'b1, 16'h0100, KF, 1'b0, 1'b0, 1'b0);
    m.idle();
    reset = 1'b1;
    @(negedge clk_sys);
    reset = 1'b0;
    check({total_valid, fetch_count}, 9'h000);
    check(state_total, 16'h0000);
    m.cyc(1'b1, 16'h0100, KF, 1'b0, 1'b0, 1'b1);
    ended(16'h0002);
  endtask
  task automatic close_out();
    $display("checks %0d mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  initial begin
    #20000;
    n_fail++;
    close_out();
  end
  initial begin
    reset = 1'b1;
    repeat (5) @(negedge clk_sys);
    reset = 1'b0;
    t_imm32(8'h12, 1'b1);
    t_imm32(8'h63, 1'b0);
    t_imm_fault();
    t_bit_ram();
    t_call();
    t_periph();
    t_mix();
    t_restart();
    t_reset();
    close_out();
  end
endmodule // test_instruction_state_counter
